// ### bench/scm_ctrl_properties.sv
/*
 * Port-level checker for scm_ctrl: halt pulses, mode enables, read data.
 * Assumes it is bound to scm_ctrl and that halt pulses never overlap.
 */
`timescale 1ns/100ps
`default_nettype none
module scm_ctrl_checker
    import scm_pkg::*;
(
    input wire logic              sys_clk_i,
    input wire logic              sys_rst_i,
    input wire scm_pkg::scm_bus_t bus_i,
    input wire logic [7:0]        rdata_o,
    input wire logic              halt_i,
    input wire scm_pkg::scm_clk_t clk_en_o,
    input wire logic              powerdown_set_o,
    input wire logic              timeout_clr_o,
    input wire logic              wdt_clear_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_halt_pulses;
        halt_i && clk_en_o.cpu_en |=> powerdown_set_o && timeout_clr_o && wdt_clear_o;
    endproperty
    a_halt_pulses: assert property (p_halt_pulses) else $error("halt pulses missing");

    property p_pd_cause;
        powerdown_set_o |-> $past(halt_i);
    endproperty
    a_pd_cause: assert property (p_pd_cause) else $error("powerdown without halt");

    property p_cpu_stop;
        halt_i && clk_en_o.cpu_en |-> ##2 !clk_en_o.cpu_en;
    endproperty
    a_cpu_stop: assert property (p_cpu_stop) else $error("cpu still on after halt");

    property p_run_clocks;
        clk_en_o.cpu_en |-> clk_en_o.sys_en && clk_en_o.slow_osc_en && clk_en_o.tbc_en;
    endproperty
    a_run_clocks: assert property (p_run_clocks) else $error("run mode clock off");

    property p_tbc_src;
        clk_en_o.tbc_en |-> clk_en_o.slow_osc_en;
    endproperty
    a_tbc_src: assert property (p_tbc_src) else $error("time base without slow osc");

    property p_fast_div;
        clk_en_o.fast_div_en |-> clk_en_o.fast_osc_en;
    endproperty
    a_fast_div: assert property (p_fast_div) else $error("divided clock without fast");

    property p_sleep_all;
        !clk_en_o.slow_osc_en |-> !(clk_en_o.sys_en || clk_en_o.tbc_en || clk_en_o.fast_osc_en);
    endproperty
    a_sleep_all: assert property (p_sleep_all) else $error("clock on in deep sleep");

    property p_rd_unmapped;
        $past(bus_i.rd) && ($past(bus_i.addr) > SCM_REG_STATE) |-> rdata_o == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read nonzero");
endmodule
`default_nettype wire

// ### bench/scm_osc_model.sv
/*
 * Behavioural fast and slow oscillators plus fast stability flag.
 * Assumes enables come from scm_ctrl; a stopped oscillator holds its level.
 */
`timescale 1ns/100ps
`default_nettype none
module scm_osc_model #(
    parameter int FAST_HALF = 3,
    parameter int SLOW_HALF = 40,
    parameter int SETTLE    = 20
) (
    input  wire logic sys_clk_i,
    input  wire logic fast_en_i,
    input  wire logic slow_en_i,
    output logic      fast_tick_o,
    output logic      slow_tick_o,
    output logic      fast_stable_o
);
    int fcnt = 0;
    int scnt = 0;
    int up = 0;
    initial begin
        fast_tick_o = 1'b0;
        slow_tick_o = 1'b0;
        fast_stable_o = 1'b0;
    end
    always @(posedge sys_clk_i) begin
        if (fast_en_i) begin
            fcnt = (fcnt + 1) % FAST_HALF;
            if (fcnt == 0) fast_tick_o <= ~fast_tick_o;
        end
        if (slow_en_i) begin
            scnt = (scnt + 1) % SLOW_HALF;
            if (scnt == 0) slow_tick_o <= ~slow_tick_o;
        end
        // Restart costs a settling time, so ready must lag enable
        up = fast_en_i ? up + 1 : 0;
        fast_stable_o <= (up > SETTLE);
    end
endmodule
`default_nettype wire

// ### bench/test_system_clock_mode_control.sv
/*
 * Self-checking bench for scm_ctrl: registers, flags, clock select, halt modes.
 * Assumes scm_osc_model stands in for both oscillators.
 */
`timescale 1ns/100ps
`default_nettype none
bind scm_ctrl scm_ctrl_checker u_scm_ctrl_checker (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .halt_i(halt_i), .clk_en_o(clk_en_o), .powerdown_set_o(powerdown_set_o),
    .timeout_clr_o(timeout_clr_o), .wdt_clear_o(wdt_clear_o));
module test_system_clock_mode_control;
    import scm_pkg::*;
    logic       sys_clk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    scm_bus_t   bus = '0;
    logic [7:0] rdata;
    logic       halt = 1'b0, wake = 1'b0, wdt_en = 1'b0, lvd_en = 1'b0;
    logic       crf_evt = 1'b0, bor_evt = 1'b0, wrf_evt = 1'b0;
    logic       f_tick, s_tick, f_stable, sys_tick, tbc_tick, pd, to_clr, wdt_clr, irq;
    scm_clk_t   en;
    int         num_errors = 0;
    int         checks_done = 0;

    scm_ctrl u_scm_ctrl (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus), .rdata_o(rdata),
        .halt_i(halt), .wake_i(wake), .fast_tick_i(f_tick), .slow_tick_i(s_tick),
        .fast_stable_i(f_stable), .wdt_enable_i(wdt_en), .lvd_enable_i(lvd_en),
        .ctrl_reset_evt_i(crf_evt), .brownout_evt_i(bor_evt), .wdt_sw_reset_evt_i(wrf_evt),
        .clk_en_o(en), .sys_tick_o(sys_tick), .tbc_tick_o(tbc_tick), .powerdown_set_o(pd),
        .timeout_clr_o(to_clr), .wdt_clear_o(wdt_clr), .irq_o(irq));
    scm_osc_model u_scm_osc_model (
        .sys_clk_i(sys_clk_i), .fast_en_i(en.fast_osc_en), .slow_en_i(en.slow_osc_en),
        .fast_tick_o(f_tick), .slow_tick_o(s_tick), .fast_stable_o(f_stable));

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk_i);
        bus <= '0;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] m);
        @(posedge sys_clk_i);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk_i);
        bus <= '0;
        #1 chk(rdata & m, exp);
    endtask
    // Counts source edges and system ticks over one fixed window
    task automatic measure(input logic use_slow, output int src, output int sy);
        logic pf, ps;
        src = 0;
        sy = 0;
        pf = f_tick;
        ps = s_tick;
        repeat (3072) begin
            @(posedge sys_clk_i);
            if (use_slow ? (s_tick && !ps) : (f_tick && !pf)) src++;
            if (sys_tick === 1'b1) sy++;
            pf = f_tick;
            ps = s_tick;
        end
    endtask

    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        #300000;
        num_errors++;
        $display("CHECK FAILED t=%0t run timed out", $time);
        tally_and_finish();
    end
    initial begin
        int seed, src, sy, div, ex, v;
        seed = $urandom(54176);
        cyc(10);
        sys_rst_i <= 1'b0;
        rdc(SCM_REG_MODE, 8'h03, 8'hFF);
        rdc(SCM_REG_AUX, 8'h00, 8'hFF);
        rdc(3'h6, 8'h00, 8'hFF);
        $display("reset values done");
        wr(SCM_REG_AUX, 8'hFF);
        rdc(SCM_REG_AUX, 8'h80, 8'hFF);
        wr(SCM_REG_MODE, 8'hFF);
        rdc(SCM_REG_MODE, 8'hE3, 8'hF3);
        @(posedge sys_clk_i);
        crf_evt <= 1'b1;
        bor_evt <= 1'b1;
        wrf_evt <= 1'b1;
        @(posedge sys_clk_i);
        crf_evt <= 1'b0;
        bor_evt <= 1'b0;
        wrf_evt <= 1'b0;
        rdc(SCM_REG_AUX, 8'h8D, 8'hFF);
        wr(SCM_REG_AUX, 8'h8D);
        rdc(SCM_REG_AUX, 8'h8D, 8'hFF);
        wr(SCM_REG_AUX, 8'h00);
        rdc(SCM_REG_AUX, 8'h00, 8'hFF);
        $display("register access done");
        for (int c = 0; c < 9; c++) begin
            wr(SCM_REG_MODE, (c == 8) ? 8'h01 : {c[2:0], 5'h00});
            cyc(600);
            div = (c >= 2 && c < 8) ? (1 << (8 - c)) : 1;
            measure(c < 2, src, sy);
            ex = src / div;
            checks_done++;
            if (sy < ex - 1 || sy > ex + 1) begin
                num_errors++;
                $display("CHECK FAILED t=%0t code %0d ticks %0d want %0d", $time, c, sy, ex);
            end
            chk({en.fast_osc_en, en.fast_div_en}, {c >= 2, c >= 2});
            $display("clock code %0d done", c);
        end
        rdc(SCM_REG_MODE, 8'h0C, 8'h0C);
        for (int k = 0; k < 4; k++) begin
            v = (k == 3) ? $urandom_range(3, 1) : 0;
            wr(SCM_REG_AUX, {k == 1, 7'h00});
            // Levels change right on the edge, never between edges
            wdt_en <= v[0];
            lvd_en <= v[1];
            wr(SCM_REG_MODE, {6'h00, k < 2, 1'b1});
            wr(SCM_REG_IRQ_MASK, {7'h00, k != 3});
            wr(SCM_REG_IRQ_STAT, 8'hFF);
            @(posedge sys_clk_i);
            halt <= 1'b1;
            @(posedge sys_clk_i);
            halt <= 1'b0;
            #1 chk({5'h00, pd, to_clr, wdt_clr}, 8'h07);
            cyc(3);
            #1;
            chk({en.cpu_en, en.sys_en, en.slow_osc_en, en.tbc_en}, {k == 1, k != 2, k < 2});
            chk(8'(irq), 8'(k != 3));
            rdc(SCM_REG_STATE, 8'(k + 2), 8'hFF);
            if (k == 2) rdc(SCM_REG_MODE, 8'h00, 8'h08);
            // Time base ticks only while it is enabled in the halt mode
            ex = 0;
            repeat (200) begin
                @(posedge sys_clk_i);
                if (tbc_tick === 1'b1) ex++;
            end
            chk(8'(ex > 0), 8'(k < 2));
            @(posedge sys_clk_i);
            wake <= 1'b1;
            @(posedge sys_clk_i);
            wake <= 1'b0;
            cyc(300);
            rdc(SCM_REG_STATE, 8'h00, 8'hFF);
            rdc(SCM_REG_MODE, 8'h08, 8'h08);
            wr(SCM_REG_IRQ_STAT, 8'hFF);
            cyc(2);
            #1 chk(8'(irq), 8'h00);
            $display("halt case %0d done", k);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ### common/scm_pkg.sv
/*
 * Package for the system clock and operating mode controller: register
 * indices, field positions, reset values, clock selections and mode states.
 * Assumes a single 250 MHz system clock and a plain register port.
 */
package scm_pkg;

    localparam int          SCM_ADDR_W       = 3;
    localparam logic [2:0]  SCM_REG_MODE     = 3'h0;
    localparam logic [2:0]  SCM_REG_AUX      = 3'h1;
    localparam logic [2:0]  SCM_REG_IRQ_STAT = 3'h2;
    localparam logic [2:0]  SCM_REG_IRQ_MASK = 3'h3;
    localparam logic [2:0]  SCM_REG_STATE    = 3'h4;

    // Mode register fields
    localparam int          SCM_MODE_HSEL    = 0;
    localparam int          SCM_MODE_IDLE    = 1;
    localparam int          SCM_MODE_HRDY    = 2;
    localparam int          SCM_MODE_LRDY    = 3;
    localparam int          SCM_MODE_DIV_LO  = 5;
    localparam logic [7:0]  SCM_MODE_WMASK   = 8'hE3;
    localparam logic [7:0]  SCM_MODE_RST     = 8'h03;

    // Aux flag register fields
    localparam int          SCM_AUX_WRF      = 0;
    localparam int          SCM_AUX_BOR      = 2;
    localparam int          SCM_AUX_CRF      = 3;
    localparam int          SCM_AUX_SYSON    = 7;
    localparam logic [7:0]  SCM_AUX_RST      = 8'h00;

    // Interrupt status bits
    localparam int          SCM_IRQ_HALT     = 0;
    localparam int          SCM_IRQ_WAKE     = 1;
    localparam int          SCM_IRQ_LRDY     = 2;
    localparam int          SCM_IRQ_HRDY     = 3;
    localparam int          SCM_IRQ_N        = 4;

    localparam logic [2:0]  SCM_DIV_LOW_A    = 3'h0;
    localparam logic [2:0]  SCM_DIV_LOW_B    = 3'h1;
    localparam logic [2:0]  SCM_DIV_BASE     = 3'h2;

    localparam int          SCM_FAST_DIV_W   = 6;
    localparam int          SCM_LRDY_SYNC_N  = 2;

    typedef enum logic [2:0] {
        SCM_ST_NORMAL,
        SCM_ST_SLOW,
        SCM_ST_IDLE0,
        SCM_ST_IDLE1,
        SCM_ST_SLEEP0,
        SCM_ST_SLEEP1
    } scm_state_t;

    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [SCM_ADDR_W-1:0] addr;
        logic [7:0]            wdata;
    } scm_bus_t;

    typedef struct packed {
        logic cpu_en;
        logic sys_en;
        logic fast_osc_en;
        logic slow_osc_en;
        logic tbc_en;
        logic fast_div_en;
    } scm_clk_t;

endpackage

// ### design/scm_ctrl.sv
/*
 * System clock and operating mode controller. Builds clock enables for the
 * CPU, system clock, fast/slow oscillators and time base, runs the halt
 * mode decision and holds the two mode registers plus an interrupt pair.
 * Assumes oscillator tick and ready pins are asynchronous and the CPU
 * gives one-cycle halt and wake pulses on this clock.
 */
`timescale 1ns/100ps
`default_nettype none

module scm_ctrl #(
    parameter int DIV_W = scm_pkg::SCM_FAST_DIV_W
) (
    input  wire logic             sys_clk_i,
    input  wire logic             sys_rst_i,
    input  wire scm_pkg::scm_bus_t bus_i,
    output logic [7:0]            rdata_o,
    input  wire logic             halt_i,
    input  wire logic             wake_i,
    input  wire logic             fast_tick_i,
    input  wire logic             slow_tick_i,
    input  wire logic             fast_stable_i,
    input  wire logic             wdt_enable_i,
    input  wire logic             lvd_enable_i,
    input  wire logic             ctrl_reset_evt_i,
    input  wire logic             brownout_evt_i,
    input  wire logic             wdt_sw_reset_evt_i,
    output scm_pkg::scm_clk_t     clk_en_o,
    output logic                  sys_tick_o,
    output logic                  tbc_tick_o,
    output logic                  powerdown_set_o,
    output logic                  timeout_clr_o,
    output logic                  wdt_clear_o,
    output logic                  irq_o
);
    import scm_pkg::*;

    // Pin synchronisers: fast tick, slow tick, fast stable
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic [2:0] prev_ff;
    logic       fast_edge;
    logic       slow_edge;
    logic       fast_ok;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            prev_ff  <= 3'h0;
        end else begin
            sync1_ff <= {fast_stable_i, slow_tick_i, fast_tick_i};
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    assign fast_edge = sync2_ff[0] & ~prev_ff[0];
    assign slow_edge = sync2_ff[1] & ~prev_ff[1];
    assign fast_ok   = sync2_ff[2];

    // Registers and mode state
    logic [7:0]           mode_ff, nxt_mode;
    logic [7:0]           aux_ff, nxt_aux;
    logic [SCM_IRQ_N-1:0] stat_ff, nxt_stat;
    logic [SCM_IRQ_N-1:0] mask_ff, nxt_mask;
    scm_state_t           state_ff, nxt_state;
    logic [SCM_LRDY_SYNC_N-1:0] lcnt_ff, nxt_lcnt;
    logic                 lrdy_ff, nxt_lrdy;
    logic                 hrdy_ff, nxt_hrdy;
    logic [7:0]           rdata_ff, nxt_rdata;
    logic                 pd_ff, nxt_pd;

    logic       hsel;
    logic [2:0] dsel;
    logic       want_slow;
    logic       asleep;
    logic       wr_mode;
    logic       wr_aux;
    logic [SCM_IRQ_N-1:0] evt;

    assign hsel      = mode_ff[SCM_MODE_HSEL];
    assign dsel      = mode_ff[7:SCM_MODE_DIV_LO];
    assign want_slow = ~hsel & ((dsel == SCM_DIV_LOW_A) | (dsel == SCM_DIV_LOW_B));
    assign asleep    = (state_ff != SCM_ST_NORMAL) & (state_ff != SCM_ST_SLOW);
    assign wr_mode   = bus_i.wr & (bus_i.addr == SCM_REG_MODE);
    assign wr_aux    = bus_i.wr & (bus_i.addr == SCM_REG_AUX);

    always_comb begin
        nxt_state = state_ff;
        nxt_pd    = 1'b0;
        case (state_ff)
            SCM_ST_NORMAL, SCM_ST_SLOW: begin
                nxt_state = want_slow ? SCM_ST_SLOW : SCM_ST_NORMAL;
                if (halt_i) begin
                    nxt_pd = 1'b1;
                    if (mode_ff[SCM_MODE_IDLE]) begin
                        nxt_state = aux_ff[SCM_AUX_SYSON] ? SCM_ST_IDLE1
                                                          : SCM_ST_IDLE0;
                    end else if (wdt_enable_i | lvd_enable_i) begin
                        nxt_state = SCM_ST_SLEEP1;
                    end else begin
                        nxt_state = SCM_ST_SLEEP0;
                    end
                end
            end
            SCM_ST_IDLE0, SCM_ST_IDLE1, SCM_ST_SLEEP0, SCM_ST_SLEEP1: begin
                if (wake_i) begin
                    nxt_state = want_slow ? SCM_ST_SLOW : SCM_ST_NORMAL;
                end
            end
            default: nxt_state = SCM_ST_NORMAL;
        endcase
    end

    // Ready flags
    always_comb begin
        nxt_lcnt = lcnt_ff;
        nxt_lrdy = lrdy_ff;
        if (state_ff == SCM_ST_SLEEP0) begin
            nxt_lcnt = '0;
            nxt_lrdy = 1'b0;
        end else if (!lrdy_ff && slow_edge) begin
            nxt_lcnt = lcnt_ff + 1'b1;
            if (lcnt_ff == SCM_LRDY_SYNC_N[SCM_LRDY_SYNC_N-1:0] - 1'b1) begin
                nxt_lrdy = 1'b1;
            end
        end
        // Fast flag drops while oscillator is off, set again once stable
        nxt_hrdy = clk_run_fast() & fast_ok;
    end

    function automatic logic clk_run_fast();
        clk_run_fast = ~want_slow & ((state_ff == SCM_ST_NORMAL) |
                                     (state_ff == SCM_ST_IDLE1));
    endfunction

    // Register writes, sticky flags and interrupt status
    always_comb begin
        nxt_mode = mode_ff;
        nxt_aux  = aux_ff;
        nxt_mask = mask_ff;
        if (wr_mode) begin
            nxt_mode = (mode_ff & ~SCM_MODE_WMASK) | (bus_i.wdata & SCM_MODE_WMASK);
        end
        nxt_mode[SCM_MODE_LRDY] = lrdy_ff;
        nxt_mode[SCM_MODE_HRDY] = hrdy_ff;
        if (wr_aux) begin
            nxt_aux[SCM_AUX_SYSON] = bus_i.wdata[SCM_AUX_SYSON];
            // Flag bits accept clear only
            nxt_aux[SCM_AUX_CRF] = aux_ff[SCM_AUX_CRF] & bus_i.wdata[SCM_AUX_CRF];
            nxt_aux[SCM_AUX_BOR] = aux_ff[SCM_AUX_BOR] & bus_i.wdata[SCM_AUX_BOR];
            nxt_aux[SCM_AUX_WRF] = aux_ff[SCM_AUX_WRF] & bus_i.wdata[SCM_AUX_WRF];
        end
        // Events win over a same-cycle clear
        if (ctrl_reset_evt_i) begin
            nxt_aux[SCM_AUX_CRF] = 1'b1;
        end
        if (brownout_evt_i) begin
            nxt_aux[SCM_AUX_BOR] = 1'b1;
        end
        if (wdt_sw_reset_evt_i) begin
            nxt_aux[SCM_AUX_WRF] = 1'b1;
        end
        if (bus_i.wr && bus_i.addr == SCM_REG_IRQ_MASK) begin
            nxt_mask = bus_i.wdata[SCM_IRQ_N-1:0];
        end
        evt = '0;
        evt[SCM_IRQ_HALT] = nxt_pd;
        evt[SCM_IRQ_WAKE] = asleep & wake_i;
        evt[SCM_IRQ_LRDY] = nxt_lrdy & ~lrdy_ff;
        evt[SCM_IRQ_HRDY] = nxt_hrdy & ~hrdy_ff;
        nxt_stat = stat_ff;
        if (bus_i.wr && bus_i.addr == SCM_REG_IRQ_STAT) begin
            nxt_stat = stat_ff & ~bus_i.wdata[SCM_IRQ_N-1:0];
        end
        nxt_stat = nxt_stat | evt;
        nxt_rdata = 8'h00;
        if (bus_i.rd) begin
            case (bus_i.addr)
                SCM_REG_MODE:     nxt_rdata = mode_ff & 8'hEF;
                SCM_REG_AUX:      nxt_rdata = aux_ff & 8'h8D;
                SCM_REG_IRQ_STAT: nxt_rdata = {{(8-SCM_IRQ_N){1'b0}}, stat_ff};
                SCM_REG_IRQ_MASK: nxt_rdata = {{(8-SCM_IRQ_N){1'b0}}, mask_ff};
                SCM_REG_STATE:    nxt_rdata = {5'h00, state_ff};
                default:          nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            mode_ff  <= SCM_MODE_RST;
            aux_ff   <= SCM_AUX_RST;
            stat_ff  <= '0;
            mask_ff  <= '0;
            state_ff <= SCM_ST_NORMAL;
            lcnt_ff  <= '0;
            lrdy_ff  <= 1'b0;
            hrdy_ff  <= 1'b0;
            rdata_ff <= 8'h00;
            pd_ff    <= 1'b0;
        end else begin
            mode_ff  <= nxt_mode;
            aux_ff   <= nxt_aux;
            stat_ff  <= nxt_stat;
            mask_ff  <= nxt_mask;
            state_ff <= nxt_state;
            lcnt_ff  <= nxt_lcnt;
            lrdy_ff  <= nxt_lrdy;
            hrdy_ff  <= nxt_hrdy;
            rdata_ff <= nxt_rdata;
            pd_ff    <= nxt_pd;
        end
    end

    // Fast divider: ratio applied only when the counter wraps, at a slow edge while on the slow source,
    // or while the fast clock is stopped, so a new ratio never shortens a running period
    logic [DIV_W-1:0] dcnt_ff, nxt_dcnt;
    logic [DIV_W-1:0] dlim_ff, nxt_dlim;
    logic             src_slow_ff, nxt_src_slow;
    logic             sys_tick_ff, nxt_sys_tick;
    logic             tbc_tick_ff, nxt_tbc_tick;
    logic [DIV_W-1:0] want_lim;
    logic             wrap;
    scm_clk_t         clk_ff, nxt_clk;

    always_comb begin
        if (hsel) begin
            want_lim = '0;
        end else begin
            // Code 010 gives /64 down to 111 giving /2
            want_lim = DIV_W'((64 >> (dsel - SCM_DIV_BASE)) - 1);
        end
    end

    assign wrap = (dcnt_ff >= dlim_ff);

    always_comb begin
        nxt_dcnt     = dcnt_ff;
        nxt_dlim     = dlim_ff;
        nxt_src_slow = src_slow_ff;
        nxt_sys_tick = 1'b0;
        if (fast_edge && clk_run_fast()) begin
            nxt_dcnt = wrap ? '0 : dcnt_ff + 1'b1;
        end
        // Source and ratio swap at a period boundary of the old clock, or at once when the old fast clock is stopped
        if (src_slow_ff ? slow_edge : (fast_edge && wrap) || !clk_run_fast()) begin
            nxt_src_slow = want_slow;
            nxt_dlim     = want_lim;
        end
        if (state_ff == SCM_ST_NORMAL || state_ff == SCM_ST_SLOW ||
            state_ff == SCM_ST_IDLE1) begin
            nxt_sys_tick = src_slow_ff ? slow_edge : (fast_edge & wrap);
        end
        nxt_tbc_tick = slow_edge & (state_ff != SCM_ST_SLEEP0) &
                       (state_ff != SCM_ST_SLEEP1);
        nxt_clk.cpu_en      = (state_ff == SCM_ST_NORMAL) | (state_ff == SCM_ST_SLOW);
        nxt_clk.sys_en      = nxt_clk.cpu_en | (state_ff == SCM_ST_IDLE1);
        nxt_clk.fast_osc_en = clk_run_fast();
        nxt_clk.fast_div_en = clk_run_fast() & hrdy_ff;
        nxt_clk.slow_osc_en = (state_ff != SCM_ST_SLEEP0);
        nxt_clk.tbc_en      = (state_ff != SCM_ST_SLEEP0) & (state_ff != SCM_ST_SLEEP1);
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            dcnt_ff     <= '0;
            dlim_ff     <= '0;
            src_slow_ff <= 1'b0;
            sys_tick_ff <= 1'b0;
            tbc_tick_ff <= 1'b0;
            clk_ff      <= '0;
        end else begin
            dcnt_ff     <= nxt_dcnt;
            dlim_ff     <= nxt_dlim;
            src_slow_ff <= nxt_src_slow;
            sys_tick_ff <= nxt_sys_tick;
            tbc_tick_ff <= nxt_tbc_tick;
            clk_ff      <= nxt_clk;
        end
    end

    // Interrupt held in a flop to keep outputs registered
    logic irq_ff;
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(nxt_stat & nxt_mask);
        end
    end

    assign rdata_o         = rdata_ff;
    assign clk_en_o        = clk_ff;
    assign sys_tick_o      = sys_tick_ff;
    assign tbc_tick_o      = tbc_tick_ff;
    assign powerdown_set_o = pd_ff;
    assign timeout_clr_o   = pd_ff;
    assign wdt_clear_o     = pd_ff;
    assign irq_o           = irq_ff;

endmodule

`default_nettype wire
